// ---- adcrs_port.sv ----
// Notes on behaviour
// - Transfer takes bits over lane count times one interface clock period.
// - Bits go out MSB first; host may stop clocking early.
// - In LVDS mode each extra load count delays the MSB by one interface clock.
// - In LVDS mode the MSB appears on falling edge number load count plus one.
// - Swing field picks one of three levels; resets to the middle one.
// - Pattern check replaces results with a constant 20-bit word.
// - Test word is 0xac5d6; clearing the check restores results at once.
// - Port select set to one switches the port to CMOS serial read.
// - Serial mode turns off all differential drivers, echo clock included.
// - Clock pins become serial clock and chip select; data pins lanes A-D.
// - Serial data shifts out on the falling serial clock edge.
// - Lane bit resets to one lane; one selects four serial or two LVDS.
// - One lane uses output B only; four lanes map A-D to 3..0.
// - Every serial record carries an appended 24-bit CRC of its own; LVDS records carry none.
// - Serial reads sign-extend each 20-bit result to 24 bits.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "adcrs_cfg.svh"

module adcrs_port
   import adcrs_pkg::*;
#(
   parameter int          ADDR_W    = 12,
   parameter int          RES_W     = 20,
   parameter int          BUF_DEPTH = 2,
   parameter logic [23:0] CRC_POLY  = 24'h800063,
   parameter logic [23:0] CRC_INIT  = 24'hffffff
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output var  logic              awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output var  logic              wready,
   output var  logic [1:0]        bresp,
   output var  logic              bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output var  logic              arready,
   output var  logic [31:0]       rdata,
   output var  logic [1:0]        rresp,
   output var  logic              rvalid,
   input  wire logic              rready,
   input  wire logic [RES_W-1:0]  res_data,
   input  wire logic              res_valid,
   output var  logic              res_ready,
   input  wire logic              serial_clock_in,
   input  wire logic              port_select_in,
   output var  logic              first_pair_pos,
   output var  logic              first_pair_pos_oe,
   output var  logic              first_pair_neg,
   output var  logic              first_pair_neg_oe,
   output var  logic              second_pair_pos,
   output var  logic              second_pair_pos_oe,
   output var  logic              second_pair_neg,
   output var  logic              second_pair_neg_oe,
   output var  logic              echo_clock_pos,
   output var  logic              echo_clock_neg,
   output var  logic              echo_clock_oe,
   output var  logic [1:0]        output_swing_select
);

   localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Word index to register selector
   function automatic adcrs_sel_t reg_sel(input logic [ADDR_W-1:0] a);
      logic [7:0] idx;
      idx = a[9:2];
      case (idx)
         `ADCRS_IDX_CFG_FIRST: reg_sel = SEL_FIRST;
         `ADCRS_IDX_CFG_LOAD:  reg_sel = SEL_LOAD;
         `ADCRS_IDX_CFG_THIRD: reg_sel = SEL_THIRD;
         `ADCRS_IDX_STATUS:    reg_sel = SEL_STATUS;
         default:              reg_sel = SEL_NONE;
      endcase
   endfunction

   // CRC over a 24-bit word, MSB first
   function automatic logic [23:0] crc24(input logic [23:0] d);
      logic [23:0] c;
      c = CRC_INIT;
      for (int i = 23; i >= 0; i--) begin
         c = (c[23] ^ d[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      crc24 = c;
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic clk_s1_r, clk_s2_r, clk_s3_r;
   logic cs_s1_r, cs_s2_r, cs_s3_r;

   // Two flops per pin, third flop for edges
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_s1_r <= 1'b0;
         clk_s2_r <= 1'b0;
         clk_s3_r <= 1'b0;
         cs_s1_r  <= 1'b1;
         cs_s2_r  <= 1'b1;
         cs_s3_r  <= 1'b1;
      end else begin
         clk_s1_r <= serial_clock_in;
         clk_s2_r <= clk_s1_r;
         clk_s3_r <= clk_s2_r;
         cs_s1_r  <= port_select_in;
         cs_s2_r  <= cs_s1_r;
         cs_s3_r  <= cs_s2_r;
      end
   end

   logic fall, cs_act, cs_fall;
   assign fall    = clk_s3_r & ~clk_s2_r;
   assign cs_act  = ~cs_s2_r;
   assign cs_fall = cs_s3_r & ~cs_s2_r;

   // ----------------------------------------------------------------
   // Register slave
   // ----------------------------------------------------------------
   logic              aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
   logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
   logic [31:0]       w_data_r, w_data_nxt;
   logic              w_lane0_r, w_lane0_nxt;
   logic              bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0]       rdata_r, rdata_nxt;
   logic [2:0]        first_r, first_nxt;
   logic [3:0]        load_cnt_r, load_cnt_nxt;
   logic [1:0]        swing_r, swing_nxt;
   adcrs_state_t      st_r, st_nxt;
   logic [PW:0]       count_r, count_nxt;

   logic spi, quad, chk;
   assign spi = first_r[`ADCRS_BIT_PORT_SEL];
   assign quad = first_r[`ADCRS_BIT_QUAD];
   assign chk = first_r[`ADCRS_BIT_CHECK];

   assign awready = ~aw_got_r & ~bvalid_r;
   assign wready  = ~w_got_r & ~bvalid_r;
   assign arready = ~rvalid_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;
   assign rvalid  = rvalid_r;
   assign rresp   = rresp_r;
   assign rdata   = rdata_r;
   assign output_swing_select = swing_r;

   // Next bus and register state
   always_comb begin
      adcrs_sel_t ws, rs;
      ws = reg_sel(aw_addr_r);
      rs = reg_sel(araddr);
      aw_got_nxt = aw_got_r;
      aw_addr_nxt = aw_addr_r;
      w_got_nxt = w_got_r;
      w_data_nxt = w_data_r;
      w_lane0_nxt = w_lane0_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      first_nxt = first_r;
      load_cnt_nxt = load_cnt_r;
      swing_nxt = swing_r;
      if (awvalid && awready) begin
         aw_got_nxt = 1'b1;
         aw_addr_nxt = awaddr;
      end
      if (wvalid && wready) begin
         w_got_nxt = 1'b1;
         w_data_nxt = wdata;
         w_lane0_nxt = wstrb[0];
      end
      if (bvalid_r && bready) begin
         bvalid_nxt = 1'b0;
      end
      // Write once both halves are held
      if (aw_got_r && w_got_r && !bvalid_r) begin
         aw_got_nxt = 1'b0;
         w_got_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = (ws == SEL_NONE) ? `ADCRS_RESP_ERR : `ADCRS_RESP_OK;
         if (w_lane0_r) begin
            case (ws)
               SEL_FIRST: first_nxt = w_data_r[2:0];
               SEL_LOAD:  load_cnt_nxt = w_data_r[3:0];
               SEL_THIRD: begin
                  if (w_data_r[1:0] <= `ADCRS_SWING_MAX) begin
                     swing_nxt = w_data_r[1:0];
                  end
               end
               default: ;
            endcase
         end
      end
      if (rvalid_r && rready) begin
         rvalid_nxt = 1'b0;
      end
      // Read data and response
      if (arvalid && arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = (rs == SEL_NONE) ? `ADCRS_RESP_ERR : `ADCRS_RESP_OK;
         case (rs)
            SEL_FIRST:  rdata_nxt = {29'h0, first_r};
            SEL_LOAD:   rdata_nxt = {28'h0, load_cnt_r};
            SEL_THIRD:  rdata_nxt = {30'h0, swing_r};
            SEL_STATUS: rdata_nxt = {25'h0, cs_act, 3'(count_r), st_r};
            default:    rdata_nxt = 32'h0;
         endcase
      end
   end

   // Register bus and configuration state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r   <= 1'b0;
         aw_addr_r  <= '0;
         w_got_r    <= 1'b0;
         w_data_r   <= 32'h0;
         w_lane0_r  <= 1'b0;
         bvalid_r   <= 1'b0;
         bresp_r    <= `ADCRS_RESP_OK;
         rvalid_r   <= 1'b0;
         rresp_r    <= `ADCRS_RESP_OK;
         rdata_r    <= 32'h0;
         first_r    <= `ADCRS_FIRST_RST;
         load_cnt_r <= `ADCRS_LOAD_RST;
         swing_r    <= `ADCRS_SWING_RST;
      end else begin
         aw_got_r   <= aw_got_nxt;
         aw_addr_r  <= aw_addr_nxt;
         w_got_r    <= w_got_nxt;
         w_data_r   <= w_data_nxt;
         w_lane0_r  <= w_lane0_nxt;
         bvalid_r   <= bvalid_nxt;
         bresp_r    <= bresp_nxt;
         rvalid_r   <= rvalid_nxt;
         rresp_r    <= rresp_nxt;
         rdata_r    <= rdata_nxt;
         first_r    <= first_nxt;
         load_cnt_r <= load_cnt_nxt;
         swing_r    <= swing_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Result buffer
   // ----------------------------------------------------------------
   logic [RES_W-1:0] mem_r [BUF_DEPTH];
   logic [PW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
   logic             push, pop, head_valid;

   assign res_ready  = (count_r != (PW+1)'(BUF_DEPTH));
   assign push       = res_valid & res_ready;
   assign head_valid = (count_r != '0);

   // Pointer and fill arithmetic
   always_comb begin
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      count_nxt = count_r;
      if (push) begin
         wp_nxt = (wp_r == PW'(BUF_DEPTH-1)) ? '0 : PW'(wp_r + 1'b1);
      end
      if (pop) begin
         rp_nxt = (rp_r == PW'(BUF_DEPTH-1)) ? '0 : PW'(rp_r + 1'b1);
      end
      if (push && !pop) begin
         count_nxt = (PW+1)'(count_r + 1'b1);
      end else if (pop && !push) begin
         count_nxt = (PW+1)'(count_r - 1'b1);
      end
   end

   // Buffer storage and pointers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wp_r    <= '0;
         rp_r    <= '0;
         count_r <= '0;
      end else begin
         wp_r    <= wp_nxt;
         rp_r    <= rp_nxt;
         count_r <= count_nxt;
         if (push) begin
            mem_r[wp_r] <= res_data;
         end
      end
   end

   // ----------------------------------------------------------------
   // Output shifter
   // ----------------------------------------------------------------
   logic [47:0] sh_r, sh_nxt;
   logic [5:0]  left_r, left_nxt;
   logic [4:0]  wait_r, wait_nxt;
   logic [RES_W-1:0] word;
   logic [23:0] sext;
   logic [5:0]  step;

   assign word = chk ? `ADCRS_PATTERN : (head_valid ? mem_r[rp_r] : '0);
   assign sext = {{(24-RES_W){word[RES_W-1]}}, word};
   assign step = quad ? (spi ? 6'h4 : 6'h2) : 6'h1;

   // Next shifter state
   always_comb begin
      st_nxt = st_r;
      sh_nxt = sh_r;
      left_nxt = left_r;
      wait_nxt = wait_r;
      pop = 1'b0;
      case (st_r)
         ST_IDLE: begin
            if (spi && cs_fall) begin
               sh_nxt = {sext, crc24(sext)};
               left_nxt = `ADCRS_REC_BITS;
               pop = ~chk & head_valid;
               st_nxt = ST_SHIFT;
            end else if (!spi && (chk || head_valid)) begin
               wait_nxt = {1'b0, load_cnt_r};
               st_nxt = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (spi) begin
               st_nxt = ST_IDLE;
            end else if (fall && wait_r == 5'h0) begin
               sh_nxt = {word, 28'h0};
               left_nxt = `ADCRS_LVDS_BITS;
               pop = ~chk & head_valid;
               st_nxt = ST_SHIFT;
            end else if (fall) begin
               wait_nxt = 5'(wait_r - 1'b1);
            end
         end
         ST_SHIFT: begin
            if (spi && !cs_act) begin
               st_nxt = ST_IDLE;
            end else if (fall) begin
               sh_nxt = sh_r << step;
               if (left_r <= step) begin
                  st_nxt = ST_IDLE;
               end else begin
                  left_nxt = 6'(left_r - step);
               end
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   // Shifter registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r   <= ST_IDLE;
         sh_r   <= 48'h0;
         left_r <= 6'h0;
         wait_r <= 5'h0;
      end else begin
         st_r   <= st_nxt;
         sh_r   <= sh_nxt;
         left_r <= left_nxt;
         wait_r <= wait_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Pin mapping
   // ----------------------------------------------------------------
   logic drive;
   assign drive = spi & cs_act;

   // Pins as differential pairs or serial lanes
   always_comb begin
      if (spi) begin
         first_pair_pos  = sh_r[47];
         first_pair_neg  = quad ? sh_r[46] : sh_r[47];
         second_pair_pos = sh_r[45];
         second_pair_neg = sh_r[44];
         first_pair_pos_oe  = drive & quad;
         first_pair_neg_oe  = drive;
         second_pair_pos_oe = drive & quad;
         second_pair_neg_oe = drive & quad;
         echo_clock_oe = 1'b0;
      end else begin
         first_pair_pos  = sh_r[47];
         first_pair_neg  = ~sh_r[47];
         second_pair_pos = sh_r[46];
         second_pair_neg = ~sh_r[46];
         first_pair_pos_oe  = 1'b1;
         first_pair_neg_oe  = 1'b1;
         second_pair_pos_oe = quad;
         second_pair_neg_oe = quad;
         echo_clock_oe = 1'b1;
      end
      echo_clock_pos = clk_s2_r;
      echo_clock_neg = ~clk_s2_r;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_spi_load;
      st_r == ST_IDLE && spi && cs_fall;
   endsequence

   sequence s_lvds_load;
      st_r == ST_WAIT && !spi && fall && wait_r == 5'h0;
   endsequence

   a_reset_cfg: assert property (
      $rose(aresetn) |-> swing_r == `ADCRS_SWING_RST && !quad && !spi)
      else $error("config not at reset values");
   a_swing_legal: assert property (
      swing_r <= `ADCRS_SWING_MAX) else $error("swing setting out of range");
   a_crc_append: assert property (
      s_spi_load |=> sh_r[23:0] == crc24(sh_r[47:24]))
      else $error("record crc wrong");
   a_sign_ext: assert property (
      s_spi_load |=> sh_r[47:43] == {5{sh_r[43]}}) else $error("result not sign extended");
   a_check_word: assert property (
      (s_lvds_load ##0 chk) |=> sh_r[47:28] == `ADCRS_PATTERN)
      else $error("pattern word not sent");
   a_lvds_len: assert property (
      s_lvds_load |=> left_r == `ADCRS_LVDS_BITS && st_r == ST_SHIFT)
      else $error("record length wrong");
   a_load_count: assert property (
      (st_r == ST_IDLE && !spi && (chk || head_valid))
      |=> st_r == ST_WAIT && wait_r == {1'b0, $past(load_cnt_r)})
      else $error("load delay not taken");
   a_load_hold: assert property (
      (st_r == ST_WAIT && !spi && !fall) |=> st_r == ST_WAIT && $stable(wait_r))
      else $error("load delay moved without edge");
   a_msb_first: assert property (
      (st_r == ST_SHIFT && fall && !quad && left_r > 6'h1 && !(spi && !cs_act))
      |=> sh_r[47] == $past(sh_r[46])) else $error("bit order wrong");
   a_shift_fall: assert property (
      (st_r == ST_SHIFT && !fall) |=> $stable(sh_r)) else $error("shift without falling edge");
   a_serial_off: assert property (
      spi |-> !echo_clock_oe && !(first_pair_pos_oe && !quad))
      else $error("differential driver on in serial mode");
   a_cs_gate: assert property (
      (spi && !cs_act) |-> !first_pair_neg_oe && !second_pair_neg_oe)
      else $error("lane driven without select");
   a_one_lane: assert property (
      (spi && !quad) |-> !second_pair_pos_oe && first_pair_neg == sh_r[47])
      else $error("single lane not on output b");
   a_pin_map: assert property (
      (spi && quad && cs_act) |-> first_pair_pos == sh_r[47] && second_pair_neg == sh_r[44])
      else $error("quad lane order wrong");

endmodule // adcrs_port
`default_nettype wire

// ---- adcrs_cfg.svh ----
`ifndef ADCRS_CFG_SVH
`define ADCRS_CFG_SVH
// Register indices, byte address is four times the index
`define ADCRS_IDX_CFG_FIRST 8'h15
`define ADCRS_IDX_CFG_LOAD  8'h16
`define ADCRS_IDX_CFG_THIRD 8'h17
`define ADCRS_IDX_STATUS    8'h18
// Fields of the first configuration register
`define ADCRS_BIT_PORT_SEL  0
`define ADCRS_BIT_QUAD      1
`define ADCRS_BIT_CHECK     2
`define ADCRS_FIRST_RST     3'h0
// Reset values and limits
`define ADCRS_LOAD_RST      4'h0
`define ADCRS_SWING_RST     2'h1
`define ADCRS_SWING_MAX     2'h2
`define ADCRS_PATTERN       20'hac5d6
// Record lengths in bits
`define ADCRS_LVDS_BITS     6'h14
`define ADCRS_REC_BITS      6'h30
// Bus responses
`define ADCRS_RESP_OK       2'h0
`define ADCRS_RESP_ERR      2'h2
`endif

// ---- adcrs_pkg.sv ----
package adcrs_pkg;
   // Shifter states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_WAIT  = 3'b010,
      ST_SHIFT = 3'b100
   } adcrs_state_t;
   // Register selector codes
   typedef enum logic [2:0] {
      SEL_NONE   = 3'b000,
      SEL_FIRST  = 3'b001,
      SEL_LOAD   = 3'b010,
      SEL_THIRD  = 3'b011,
      SEL_STATUS = 3'b100
   } adcrs_sel_t;
endpackage

// ---- adcrs_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module adcrs_host_model (
   input  wire logic aclk,
   output var  logic serial_clock_in,
   output var  logic port_select_in,
   input  wire logic a,
   input  wire logic a_oe,
   input  wire logic b,
   input  wire logic b_oe,
   input  wire logic c,
   input  wire logic c_oe,
   input  wire logic d,
   input  wire logic d_oe
);
   // ----------------------------------------
   // Pin levels as seen by the host
   // ----------------------------------------
   // Undriven lane floats, so a capture of it never matches
   wire logic wa = a_oe ? a : 1'bz;
   wire logic wb = b_oe ? b : 1'bz;
   wire logic wc = c_oe ? c : 1'bz;
   wire logic wd = d_oe ? d : 1'bz;

   // Clock idles high and stands still between frames
   initial begin
      serial_clock_in = 1'b1;
      port_select_in  = 1'b1;
   end

   // Chip select change, then let synchronizers settle
   task automatic sel(input logic v);
      @(posedge aclk);
      port_select_in <= v;
      repeat (8) @(posedge aclk);
   endtask

   // Sample lanes, then one slow clock period (13 aclk)
   // Mode 0 lane A, 1 lane B, 2 all four lanes A..D
   task automatic xfer(input int n, input int m, output logic [47:0] cap);
      cap = 48'h0;
      repeat (n) begin
         @(negedge aclk);
         if (m == 0) cap = {cap[46:0], wa};
         else if (m == 1) cap = {cap[46:0], wb};
         else cap = {cap[43:0], wa, wb, wc, wd};
         @(posedge aclk);
         serial_clock_in <= 1'b0;
         repeat (6) @(posedge aclk);
         serial_clock_in <= 1'b1;
         repeat (6) @(posedge aclk);
      end
   endtask
endmodule // adcrs_host_model

`default_nettype wire

// ---- adcrs_port_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module adcrs_port_test;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, res_valid, res_ready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, output_swing_select;
   logic [19:0] res_data;
   logic        serial_clock_in, port_select_in, echo_clock_oe, echo_clock_pos, echo_clock_neg;
   logic        first_pair_pos, first_pair_pos_oe, first_pair_neg, first_pair_neg_oe;
   logic        second_pair_pos, second_pair_pos_oe, second_pair_neg, second_pair_neg_oe;
   logic [47:0] cap;
   int          n_fail, n_tests, cnt;

   adcrs_port adcrs_port_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .res_data, .res_valid,
      .res_ready, .serial_clock_in, .port_select_in, .first_pair_pos,
      .first_pair_pos_oe, .first_pair_neg, .first_pair_neg_oe, .second_pair_pos,
      .second_pair_pos_oe, .second_pair_neg, .second_pair_neg_oe,
      .echo_clock_pos, .echo_clock_neg, .echo_clock_oe, .output_swing_select);

   adcrs_host_model adcrs_host_model_i (.aclk, .serial_clock_in, .port_select_in,
      .a(first_pair_pos), .a_oe(first_pair_pos_oe), .b(first_pair_neg),
      .b_oe(first_pair_neg_oe), .c(second_pair_pos), .c_oe(second_pair_pos_oe),
      .d(second_pair_neg), .d_oe(second_pair_neg_oe));

   // ----------------------------------------
   // Clock and hang guard
   // ----------------------------------------
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // Whole run needs under two thousand cycles
   always @(posedge aclk) begin
      cnt <= cnt + 1;
      if (cnt == 20000) begin
         n_fail++;
         results();
      end
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic results();
      if (n_fail == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic cmp(input logic [47:0] got, input logic [47:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // AXI4-Lite write, both channels offered together
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw_t, w_t, g;
      g = 1'b0;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!g) begin
         @(negedge aclk);
         aw_t = awvalid && awready === 1'b1;
         w_t  = wvalid && wready === 1'b1;
         g    = bvalid === 1'b1;
         if (g) cmp(bresp, r, "write response");
         @(posedge aclk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask

   // AXI4-Lite read with data and response check
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ar_t, g;
      g = 1'b0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!g) begin
         @(negedge aclk);
         ar_t = arvalid && arready === 1'b1;
         g    = rvalid === 1'b1;
         if (g) cmp({rresp, rdata}, {r, d}, "read data");
         @(posedge aclk);
         if (ar_t) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask

   // One result into the buffer
   task automatic push(input logic [19:0] d);
      @(posedge aclk);
      res_data  <= d;
      res_valid <= 1'b1;
      do @(negedge aclk); while (res_ready !== 1'b1);
      @(posedge aclk);
      res_valid <= 1'b0;
   endtask

   function automatic logic [47:0] rec(input logic [19:0] w);
      logic [23:0] s, c;
      s = {{4{w[19]}}, w};
      c = 24'hffffff;
      for (int i = 23; i >= 0; i--)
         c = {c[22:0], 1'b0} ^ ((c[23] ^ s[i]) ? 24'h800063 : 24'h0);
      return {s, c};
   endfunction

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, res_valid} = '0;
      {awaddr, araddr, wdata, res_data, n_fail, n_tests, cnt} = '0;
      wstrb = 4'hf;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values, unmapped places, swing field
      rd(12'h054, 32'h0, 2'h0);
      rd(12'h05c, 32'h1, 2'h0);
      rd(12'h060, 32'h1, 2'h0);
      rd(12'h100, 32'h0, 2'h2);
      wr(12'h100, 32'h5, 2'h2);
      wr(12'h05c, 32'h2, 2'h0);
      // Write without its low byte lane leaves the swing alone
      wstrb <= 4'he;
      wr(12'h05c, 32'h0, 2'h0);
      wstrb <= 4'hf;
      wr(12'h05c, 32'h3, 2'h0);
      rd(12'h05c, 32'h2, 2'h0);
      cmp(output_swing_select, 2'h2, "swing pins");
      cmp(echo_clock_oe, 1'b1, "echo clock on");
      cmp({echo_clock_pos, echo_clock_neg}, 2'h2, "echo clock idle high");
      // Fixed pattern with two extra load counts, before results matter
      wr(12'h058, 32'h2, 2'h0);
      wr(12'h054, 32'h4, 2'h0);
      adcrs_host_model_i.xfer(23, 0, cap);
      cmp(cap[19:0], 20'hac5d6, "pattern word");
      // Check off, real result again; the wait already counting keeps two extra counts
      wr(12'h054, 32'h0, 2'h0);
      wr(12'h058, 32'h0, 2'h0);
      push(20'h12345);
      adcrs_host_model_i.xfer(23, 0, cap);
      cmp(cap[19:0], 20'h12345, "result word");
      // Serial one lane, buffer filled until refused
      wr(12'h054, 32'h1, 2'h0);
      cmp(echo_clock_oe, 1'b0, "echo clock off");
      push(20'h80001);
      push(20'h3c0a5);
      @(negedge aclk);
      cmp(res_ready, 1'b0, "buffer full");
      rd(12'h060, 32'h11, 2'h0);
      // Early stop of first record, next select starts a fresh one
      adcrs_host_model_i.sel(1'b0);
      adcrs_host_model_i.xfer(8, 1, cap);
      cmp(cap[7:0], 8'hf8, "short read");
      adcrs_host_model_i.sel(1'b1);
      cmp(first_pair_neg_oe, 1'b0, "lane released");
      adcrs_host_model_i.sel(1'b0);
      adcrs_host_model_i.xfer(48, 1, cap);
      adcrs_host_model_i.sel(1'b1);
      cmp(cap, rec(20'h3c0a5), "one lane record");
      // Four lanes
      wr(12'h054, 32'h3, 2'h0);
      push(20'h7ffff);
      adcrs_host_model_i.sel(1'b0);
      adcrs_host_model_i.xfer(12, 2, cap);
      adcrs_host_model_i.sel(1'b1);
      cmp(cap, rec(20'h7ffff), "four lane record");
      results();
   end
endmodule // adcrs_port_test

`default_nettype wire
